//--- verilog/rxs_regs.vh
// constants for the reset and exception entry sequencer
`ifndef RXS_REGS_VH
`define RXS_REGS_VH
`define RXS_RESET_VECTOR_ADDR  16'h0000
`define RXS_CCR_IMASK_BIT      7
`define RXS_CCR_RESET_VALUE    8'h80
`define RXS_MIN_RESET_CYCLES   10
`define RXS_ADDR_W             16
`define RXS_DATA_W             8
`endif

//--- verilog/rxs_pin_sync.v
// two-flop synchroniser for the external reset pin
`timescale 1ns/10ps
module rxs_pin_sync (
    // clock and reset
    input  wire core_clk,
    input  wire rst,
    // pin in, synchronised out
    input  wire pin_n,
    output wire pin_n_sync
);
    reg stage1_reg;
    reg stage2_reg;

    // pin assumed asserted (low) during reset so release is seen cleanly
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end else begin
            stage1_reg <= pin_n;
            stage2_reg <= stage1_reg;
        end
    end

    assign pin_n_sync = stage2_reg;
endmodule // rxs_pin_sync

//--- verilog/rxs_sequencer.v
// reset and exception entry sequencer for a small cpu core
//
// Function
// RULE1: reset beats every pending interrupt request.
// RULE2: reset sequence starts the cycle after reset state is released.
// RULE3: interrupt entry waits until current instruction or exception completes.
// RULE4: pin low halts all processing at once and holds reset; here core_halt rises on the third clock edge after the pin falls.
// RULE5: outside source holds pin low at least 10 system clocks.
// RULE6: at power-up pin stays low until the clock is stable.
// RULE7: reset initialises cpu and peripherals, sets interrupt mask bit.
// RULE8: program counter is fetched from vector word at 0000-0001.
// RULE9: interrupts masked after reset until the first instruction runs.
// RULE10: first program instruction should load the stack pointer.
// RULE11: mask bit set: requests still flag but are not accepted.
// RULE12: reset pin is synchronised before its release starts the fetch.
`timescale 1ns/10ps
`include "rxs_regs.vh"
module rxs_sequencer (
    // clock and reset
    input  wire                   core_clk,
    input  wire                   rst,
    // external reset pin
    input  wire                   external_reset_pin_n,
    // vector fetch bus
    output reg  [`RXS_ADDR_W-1:0] vec_addr,
    output reg                    vec_rd,
    input  wire [`RXS_DATA_W-1:0] vec_rdata,
    // core handshake
    input  wire                   insn_done,
    input  wire                   irq_pending,
    input  wire                   ccr_imask,
    input  wire                   irq_entry_done,
    // outputs to core and peripherals
    output reg                    core_halt,
    output reg                    periph_init,
    output reg                    ccr_load,
    output reg  [`RXS_DATA_W-1:0] condition_flags_register,
    output reg                    pc_load,
    output reg  [`RXS_ADDR_W-1:0] pc_value,
    output reg                    irq_take,
    output reg                    irq_block
);
    localparam [2:0] ST_RESET = 3'h0;
    localparam [2:0] ST_INIT  = 3'h1;
    localparam [2:0] ST_VECHI = 3'h2;
    localparam [2:0] ST_VECLO = 3'h3;
    localparam [2:0] ST_FIRST = 3'h4;
    localparam [2:0] ST_RUN   = 3'h5;
    localparam [2:0] ST_IRQ   = 3'h6;

    wire       pin_n_sync;
    reg  [2:0] state_reg;
    reg  [2:0] state_next;
    reg  [`RXS_DATA_W-1:0] pc_hi_reg;

    ////////////////////////////////////////////////////////////////////////////
    rxs_pin_sync u_sync (
        .core_clk   (core_clk),
        .rst        (rst),
        .pin_n      (external_reset_pin_n),
        .pin_n_sync (pin_n_sync)
    ); // RULE12

    ////////////////////////////////////////////////////////////////////////////
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_RESET: state_next = ST_INIT; // RULE2
            ST_INIT:  state_next = ST_VECHI;
            ST_VECHI: state_next = ST_VECLO;
            ST_VECLO: state_next = ST_FIRST;
            ST_FIRST: if (insn_done) state_next = ST_RUN; // RULE9
            ST_RUN:   if (insn_done && irq_pending && !ccr_imask)
                          state_next = ST_IRQ; // RULE3 RULE11
            ST_IRQ:   if (irq_entry_done) state_next = ST_RUN; // RULE3
            default:  state_next = ST_RESET;
        endcase
        // synchronised low pin overrides everything, interrupts included
        if (!pin_n_sync)
            state_next = ST_RESET; // RULE1 RULE4
    end

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_RESET;
            pc_hi_reg <= {`RXS_DATA_W{1'b0}};
        end else begin
            state_reg <= state_next;
            if (state_reg == ST_VECHI)
                pc_hi_reg <= vec_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs, decoded from the next state so they line up with it; pc_load, pc_value and irq_take also use the current state
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            core_halt                <= 1'b1;
            periph_init              <= 1'b1;
            ccr_load                 <= 1'b0;
            condition_flags_register <= `RXS_CCR_RESET_VALUE;
            vec_rd                   <= 1'b0;
            vec_addr                 <= `RXS_RESET_VECTOR_ADDR;
            pc_load                  <= 1'b0;
            pc_value                 <= {`RXS_ADDR_W{1'b0}};
            irq_take                 <= 1'b0;
            irq_block                <= 1'b1;
        end else begin
            core_halt   <= (state_next != ST_FIRST) && (state_next != ST_RUN) &&
                           (state_next != ST_IRQ); // RULE4
            periph_init <= (state_next == ST_RESET) || (state_next == ST_INIT); // RULE7
            ccr_load    <= (state_next == ST_INIT); // RULE7
            condition_flags_register <= `RXS_CCR_RESET_VALUE; // RULE7
            vec_rd      <= (state_next == ST_VECHI) || (state_next == ST_VECLO); // RULE8
            vec_addr    <= (state_next == ST_VECLO) ? `RXS_RESET_VECTOR_ADDR + 16'h0001
                                                    : `RXS_RESET_VECTOR_ADDR; // RULE8
            pc_load     <= (state_reg == ST_VECLO) && (state_next == ST_FIRST); // RULE8
            if (state_reg == ST_VECLO)
                pc_value <= {pc_hi_reg, vec_rdata}; // RULE8
            irq_take    <= (state_reg == ST_RUN) && (state_next == ST_IRQ); // RULE3
            irq_block   <= (state_next != ST_RUN); // RULE9 RULE11
        end
    end
endmodule // rxs_sequencer

//--- sim/rxs_vec_rom.sv
// vector memory model standing in front of the sequencer
`timescale 1ns/10ps
module rxs_vec_rom (input wire [15:0] a, output wire [7:0] d);
    // unmapped reads return a pattern, not the last byte
    assign d = (a == 16'h0000) ? 8'hAB : (a == 16'h0001) ? 8'hCD : 8'h5A;
endmodule // rxs_vec_rom

//--- sim/rxs_seq_checker.sv
// assertions on the ports of the reset sequencer
`timescale 1ns/10ps
module rxs_seq_checker (
    // clock and reset
    input wire core_clk, input wire rst, input wire external_reset_pin_n,
    // vector fetch
    input wire [15:0] vec_addr, input wire vec_rd, input wire [7:0] vec_rdata,
    // core handshake
    input wire insn_done, input wire irq_pending, input wire ccr_imask, input wire irq_entry_done,
    // outputs
    input wire core_halt, input wire periph_init, input wire ccr_load,
    input wire [7:0] condition_flags_register, input wire pc_load, input wire [15:0] pc_value,
    input wire irq_take, input wire irq_block
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_fetch;
        vec_rd && vec_addr == 16'h0000 ##1 vec_rd && vec_addr == 16'h0001;
    endsequence
    sequence s_start;
        pc_load && !core_halt;
    endsequence
    a_pin_halts_core: assert property (!external_reset_pin_n |-> ##[1:3] core_halt)
        else $error("core not halted by pin");
    a_reset_beats_irq: assert property (core_halt |-> !irq_take)
        else $error("irq taken during reset");
    a_vector_fetch_order: assert property (ccr_load |=> s_fetch ##1 s_start)
        else $error("vector fetch order wrong");
    a_mask_bit_set: assert property (ccr_load |-> periph_init && condition_flags_register == 8'h80)
        else $error("flags or init wrong at reset");
    a_irq_after_done: assert property (irq_take |-> $past(insn_done && irq_pending && !ccr_imask))
        else $error("irq taken without completion");
    a_first_insn_masked: assert property (irq_take |-> !$past(irq_block))
        else $error("irq taken while blocked");
    a_release_starts: assert property ($rose(external_reset_pin_n) |-> ##[2:5] ccr_load)
        else $error("reset sequence did not start");
    a_halt_ends_at_pc: assert property ($fell(core_halt) |-> pc_load)
        else $error("halt dropped without pc load");
endmodule // rxs_seq_checker
bind rxs_sequencer rxs_seq_checker chk (.*);

//--- sim/testbench.sv
// self-checking bench for the reset sequencer
`timescale 1ns/10ps
module testbench;
    logic core_clk, rst, external_reset_pin_n, insn_done, irq_pending, ccr_imask, irq_entry_done;
    wire [15:0] vec_addr, pc_value;
    wire [7:0] vec_rdata, condition_flags_register;
    wire vec_rd, core_halt, periph_init, ccr_load, pc_load, irq_take, irq_block;
    int fails = 0, compares = 0;
    rxs_sequencer dut (.*);
    rxs_vec_rom rom (.a(vec_addr), .d(vec_rdata));
    initial begin core_clk = 0; forever #25 core_clk = ~core_clk; end
    task cmp(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin fails++; $display("ERROR %s exp %h got %h", n, e, g); end
    endtask
    task final_report;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // one task per strobe: an inout copy would only reach the pin on return
    task pulse_done;
        @(posedge core_clk) insn_done <= 1;
        @(posedge core_clk) insn_done <= 0;
        #1;
    endtask
    task pulse_entry;
        @(posedge core_clk) irq_entry_done <= 1;
        @(posedge core_clk) irq_entry_done <= 0;
        #1;
    endtask
    task t_boot;
        int n;
        n = 0;
        @(posedge core_clk) external_reset_pin_n <= 1;
        while (pc_load !== 1'b1 && n < 20) begin @(posedge core_clk); #1; n++; end
        cmp("pc_value", 16'hABCD, pc_value);
        cmp("core_halt", 0, core_halt);
        cmp("irq_block", 1, irq_block);
        cmp("flags", 16'h0080, {8'h00, condition_flags_register});
        pulse_done;
        cmp("first irq_take", 0, irq_take);
        @(posedge core_clk); #1;
        cmp("irq_block", 0, irq_block);
        $display("boot done");
    endtask
    task t_irq;
        @(posedge core_clk) ccr_imask <= 1;
        pulse_done;
        cmp("masked irq_take", 0, irq_take);
        @(posedge core_clk) ccr_imask <= 0;
        pulse_done;
        cmp("irq_take", 1, irq_take);
        cmp("irq_block in entry", 1, irq_block);
        pulse_done;
        cmp("nested irq_take", 0, irq_take);
        pulse_entry;
        @(posedge core_clk); #1;
        cmp("irq_block", 0, irq_block);
        $display("irq done");
    endtask
    task t_pin_reset;
        @(posedge core_clk) external_reset_pin_n <= 0;
        repeat (10) @(posedge core_clk);
        #1;
        cmp("core_halt", 1, core_halt);
        cmp("periph_init", 1, periph_init);
        $display("pin reset done");
    endtask
    initial begin
        repeat (2000) @(posedge core_clk);
        fails++;
        final_report;
    end
    initial begin
        // pin low through power-up, irq pending throughout to contest reset
        rst = 1; external_reset_pin_n = 0; insn_done = 0;
        irq_pending = 1; ccr_imask = 0; irq_entry_done = 0;
        repeat (6) @(posedge core_clk);
        rst <= 0;
        t_boot; t_irq; t_pin_reset; t_boot;
        final_report;
    end
endmodule // testbench
